// *** sosc_consts.vh ***
// Constants for the serial octal switch control block.
`ifndef SOSC_CONSTS_VH
`define SOSC_CONSTS_VH
// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define SOSC_WIDTH      8
`define SOSC_ALL_OFF    8'hff
`define SOSC_NO_FAULT   8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define SOSC_CLK_NS     100
`define SOSC_SO_EN_NS   200
`define SOSC_VALID_NS   125
`endif

// *** sosc_host.sv ***
// Serial host model driving select, shift clock and command data.
`timescale 1ns/10ps
module sosc_host (
  // Pins toward the device.
  output logic cs_n = 1'b1,
  output logic sclk = 1'b0,
  output logic si   = 1'b0,
  input  wire  so
);
  // One framed transfer of n bits, MSB first, 800 ns shift clock idle low.
  task xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = '0;
    cs_n = 1'b0;
    #800;
    for (int i = n - 1; i >= 0; i--)
    begin
      #200 si = w[i];
      #200 sclk = 1'b1;
      #400 r = {r[14:0], so};
      sclk = 1'b0;
    end
    #400 cs_n = 1'b1;
    si = ~si;
    #1200;
  endtask
endmodule // sosc_host

// *** sosc_props.sv ***
// Concurrent checks on the serial switch port pins.
`timescale 1ns/10ps
module sosc_props #(parameter WIDTH = 8) (
  input wire logic             mclk, reset, cs_n, sclk, si, so, so_oe, clear_n,
  input wire logic [WIDTH-1:0] fault, out_on
);
  // All checks sample on the main clock and rest during reset.
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  oe_on_a: assert property ($fell(cs_n) |-> ##[1:6] so_oe) else $error("oe late");
  oe_off_a: assert property ($rose(cs_n) |-> ##[1:6] !so_oe) else $error("oe stuck");
  oe_idle_a: assert property (cs_n [*8] |-> !so_oe) else $error("oe idle");
  oe_cause_a: assert property ($rose(so_oe) |-> !cs_n && !$past(cs_n, 3)) else $error("oe cause");
  so_hold_a: assert property ((!cs_n && !sclk) [*8] |-> $stable(so)) else $error("so moved");
  out_hold_a: assert property ((!cs_n && clear_n && fault == '0) [*8] |-> $stable(out_on)) else $error("out moved");
  clear_off_a: assert property (!clear_n [*5] |-> out_on == '0) else $error("clear");
  fault_off_a: assert property ((cs_n && $stable(fault)) [*8] |-> (out_on & fault) == '0) else $error("fault");
  // Main scenarios reached.
  cover property ($rose(so_oe));
  cover property ($changed(out_on));
  cover property (cs_n && fault != '0);
endmodule // sosc_props
bind sosc_top sosc_props #(.WIDTH(WIDTH)) u_props (.mclk(mclk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .si(si),
  .so(so), .so_oe(so_oe), .clear_n(clear_n), .fault(fault), .out_on(out_on));

// *** sosc_sync.v ***
// Two-stage synchroniser for external pins.
`timescale 1ns/10ps
module sosc_sync
#(
  parameter W = 1
)
(
  // Clock and reset.
  input  wire         mclk,
  input  wire         reset,
  // Asynchronous in, synchronised out.
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] stage1; // First stage, read only by the second.

  // Two flip-flops in series tame metastability.
  always @(posedge mclk)
  begin
    if (reset)
    begin
      stage1 <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // sosc_sync

// *** sosc_top.v ***
// Serial command and status port of an eight-channel low-side switch.
`timescale 1ns/10ps
`include "sosc_consts.vh"
module sosc_top
#(
  parameter WIDTH = `SOSC_WIDTH
)
(
  // Clock and synchronous reset.
  input  wire             mclk,
  input  wire             reset,
  // Serial link pins from the host.
  input  wire             cs_n,
  input  wire             sclk,
  input  wire             si,
  output reg              so,
  output reg              so_oe,
  // Active-low clear pin.
  input  wire             clear_n,
  // Fault detect per output; drain status is derived internally.
  input  wire [WIDTH-1:0] fault,
  // Gate drive per output, high means switch on.
  output reg  [WIDTH-1:0] out_on
);
  // ----------------------------------------
  // Derived timing
  // ----------------------------------------
  // Longest times round down, at least one cycle.
  localparam integer EN_CYC_RAW    = `SOSC_SO_EN_NS / `SOSC_CLK_NS;
  localparam integer VALID_CYC_RAW = `SOSC_VALID_NS / `SOSC_CLK_NS;
  localparam integer EN_CYC        = (EN_CYC_RAW < 1) ? 1 : EN_CYC_RAW;
  localparam integer VALID_CYC     = (VALID_CYC_RAW < 1) ? 1 : VALID_CYC_RAW;

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  wire [3:0] pins_s; // Synchronised cs_n, sclk, si, clear_n.
  wire [WIDTH-1:0] fault_s; // Synchronised fault detect inputs.

  // Select and clear pass inverted, so the synchroniser's reset value of zero
  // reads as deselected and not clearing, and no false select edge follows reset.
  sosc_sync #(.W(4)) u_pins
  (
    .mclk  (mclk),
    .reset (reset),
    .din   ({~cs_n, sclk, si, ~clear_n}),
    .dout  (pins_s)
  );

  sosc_sync #(.W(WIDTH)) u_fault
  (
    .mclk  (mclk),
    .reset (reset),
    .din   (fault),
    .dout  (fault_s)
  );

  wire cs_s    = ~pins_s[3]; // Select, active low.
  wire sclk_s  = pins_s[2]; // Shift clock.
  wire si_s    = pins_s[1]; // Command data.
  wire clr_s_n = ~pins_s[0]; // Clear, active low.

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  reg cs_d;   // Previous select level.
  reg sclk_d; // Previous shift clock level.

  // Remember last levels to find edges.
  always @(posedge mclk)
  begin
    if (reset)
    begin
      cs_d   <= 1'b1;
      sclk_d <= 1'b0;
    end
    else
    begin
      cs_d   <= cs_s;
      sclk_d <= sclk_s;
    end
  end

  wire cs_fall   = cs_d & ~cs_s;
  wire cs_rise   = ~cs_d & cs_s;
  wire sclk_rise = ~cs_s & ~sclk_d & sclk_s;
  wire sclk_fall = ~cs_s & sclk_d & ~sclk_s;

  // ----------------------------------------
  // Shift register and latches
  // ----------------------------------------
  reg [WIDTH-1:0] shreg;   // Shared command/status shift register.
  reg [WIDTH-1:0] latch;   // Latched command, one means off.
  reg [WIDTH-1:0] faulted; // Latched fault disables.
  reg             sample;  // Bit taken on the falling edge.
  reg             have_bit; // Sample waiting to be shifted in.

  // Drain status: high when the switch is not conducting.
  wire [WIDTH-1:0] drain_high = latch | faulted;

  // Shift register: load status on select fall, shift on clock edges.
  always @(posedge mclk)
  begin
    if (reset)
    begin
      shreg    <= `SOSC_ALL_OFF;
      sample   <= 1'b0;
      have_bit <= 1'b0;
    end
    else if (!clr_s_n)
    begin
      shreg    <= `SOSC_ALL_OFF;
      have_bit <= 1'b0;
    end
    else if (cs_fall)
    begin
      shreg    <= drain_high;
      have_bit <= 1'b0;
    end
    else if (sclk_fall)
    begin
      sample   <= si_s;
      have_bit <= 1'b1;
    end
    else if (sclk_rise && have_bit)
    begin
      // MSB leaves first; the new bit enters at the bottom.
      shreg    <= {shreg[WIDTH-2:0], sample};
      have_bit <= 1'b0;
    end
  end

  // Output latches take the word at select rise; fault latches off.
  integer i;
  always @(posedge mclk)
  begin
    if (reset)
    begin
      latch   <= `SOSC_ALL_OFF;
      faulted <= `SOSC_NO_FAULT;
    end
    else if (!clr_s_n)
    begin
      latch   <= `SOSC_ALL_OFF;
      faulted <= `SOSC_NO_FAULT;
    end
    else if (cs_rise)
    begin
      // Final falling-edge bit is pending until now.
      if (have_bit)
        latch <= {shreg[WIDTH-2:0], sample};
      else
        latch <= shreg;
      faulted <= `SOSC_NO_FAULT;
    end
    else if (cs_s)
    begin
      // Each channel watches only its own fault while deselected.
      for (i = 0; i < WIDTH; i = i + 1)
      begin
        if (fault_s[i] && !latch[i])
          faulted[i] <= 1'b1;
      end
    end
  end

  // Gate drive: zero command turns the switch on.
  always @(posedge mclk)
  begin
    if (reset)
      out_on <= {WIDTH{1'b0}};
    else
      out_on <= ~drain_high;
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  // Driver follows select; data is the shift register's next MSB, or the current MSB under clear.
  always @(posedge mclk)
  begin
    if (reset)
    begin
      so_oe <= 1'b0;
      so    <= 1'b0;
    end
    else
    begin
      so_oe <= ~cs_s;
      // Data follows the shift register's next value, saving a cycle of delay, except under clear where it takes the current MSB.
      if (!clr_s_n)
        so <= shreg[WIDTH-1];
      else if (cs_fall)
        so <= drain_high[WIDTH-1];
      else if (sclk_rise && have_bit)
        so <= shreg[WIDTH-2];
      else
        so <= shreg[WIDTH-1];
    end
  end
endmodule // sosc_top

// *** sosc_top_tb.sv ***
// Self-checking bench for the serial switch port.
`timescale 1ns/10ps
module sosc_top_tb;
  logic        mclk = 1'b0, reset = 1'b1, clear_n = 1'b1;
  logic [7:0]  fault = 8'h00, prev = 8'hff;
  logic [15:0] r, rows [4] = '{16'h00ff, 16'hff00, 16'ha55a, 16'h7e81};
  wire         cs_n, sclk, si, so, so_oe;
  wire  [7:0]  out_on;
  int          n_mismatch = 0, checked = 0, cyc = 0;
  sosc_top u_dut (.mclk(mclk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe),
    .clear_n(clear_n), .fault(fault), .out_on(out_on));
  sosc_host u_host (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so));
  initial forever #50 mclk = ~mclk;
  task chk(input string nm, input logic [15:0] seen, exp);
    checked++;
    n_mismatch += (seen !== exp);
    if (seen !== exp) $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
  endtask
  task close_out;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk)
    if (++cyc == 5000)
    begin
      n_mismatch++;
      close_out();
    end
  initial
  begin
    repeat (3) @(posedge mclk);
    #1 reset = 1'b0;
    chk("reset", out_on, 8'h00);
    #300;
    foreach (rows[k])
    begin
      u_host.xfer({8'h00, rows[k][15:8]}, 8, r);
      chk("status", r, prev);
      chk("out_on", out_on, rows[k][7:0]);
      prev = rows[k][15:8];
    end
    u_host.xfer(16'h12c3, 16, r);
    chk("chain", r, {prev, 8'h12});
    chk("out_on", out_on, 8'h3c);
    fault = 8'h04;
    repeat (10) @(posedge mclk);
    #1 chk("fault", out_on, 8'h38);
    fault = 8'h00;
    u_host.xfer(16'h00c3, 8, r);
    chk("fstat", r, 16'h00c7);
    clear_n = 1'b0;
    repeat (6) @(posedge mclk);
    #1 chk("clear", out_on, 8'h00);
    clear_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1 reset = 1'b1;
    repeat (3) @(posedge mclk);
    #1 reset = 1'b0;
    chk("rst_out", out_on, 8'h00);
    chk("rst_oe", so_oe, 1'b0);
    repeat (3) @(posedge mclk);
    #1 chk("idle_oe", so_oe, 1'b0);
    u_host.xfer(16'h00fe, 8, r);
    chk("rst_stat", r, 16'h00ff);
    chk("rst_on", out_on, 8'h01);
    close_out();
  end
endmodule // sosc_top_tb
